// >>> include/csid_defs.svh
/*
 * Register addresses, status bit positions, reset values and frame-check
 * constants of the object status and standard identifier tag block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CSID_DEFS_SVH
`define CSID_DEFS_SVH

// special-function register addresses
`define CSID_ADDR_STATUS 8'hB2
`define CSID_ADDR_TAG_HI 8'hBC
`define CSID_ADDR_TAG_LO 8'hBD
`define CSID_ADDR_TAG_UN 8'hBE

// object status bit positions
`define CSID_BIT_LENGTH_MISMATCH_WARNING 7
`define CSID_BIT_TRANSMIT_DONE_FLAG 6
`define CSID_BIT_RECEIVE_DONE_FLAG 5
`define CSID_BIT_BIT_ERROR_FLAG 4
`define CSID_BIT_STUFF_ERROR_FLAG 3
`define CSID_BIT_CRC_ERROR_FLAG 2
`define CSID_BIT_FORM_ERROR_FLAG 1
`define CSID_BIT_ACK_ERROR_FLAG 0

// tag low register holds identifier bits 2..0 from this position up
`define CSID_TAG_LO_LSB 5

// reset values
`define CSID_STATUS_RST 8'h00
`define CSID_RDATA_RST  8'h00

// frame check constants
`define CSID_CRC_POLY 15'h4599
`define CSID_CRC_INIT 15'h0000
`define CSID_STUFF_RUN 3'h5

`endif

// >>> include/csid_pkg.sv
/*
 * Types of the object status and identifier tag block.
 * Assumes the protocol sequencer reports its current field with csid_fld_t.
 */
package csid_pkg;

	// field the protocol sequencer is in during the current bit
	typedef enum logic [3:0] {
		FLD_IDLE      = 4'h0,
		FLD_SOF       = 4'h1,
		FLD_ARB       = 4'h2,
		FLD_CTRL      = 4'h3,
		FLD_DATA      = 4'h4,
		FLD_CRC       = 4'h5,
		FLD_CRC_DELIM = 4'h6,
		FLD_ACK_SLOT  = 4'h7,
		FLD_ACK_DELIM = 4'h8,
		FLD_EOF       = 4'h9,
		FLD_ERROR     = 4'hA
	} csid_fld_t;

	// frame checker states, gray along idle-body-crc-tail
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BODY = 2'b01,
		ST_CRC  = 2'b11,
		ST_TAIL = 2'b10
	} csid_state_t;

endpackage

// >>> include/csid_tag_if.sv
/*
 * Carrier between the status block and its identifier tag memory.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/10ps

interface csid_tag_if #(
	parameter int AW = 4
);
	logic          we_hi;
	logic          we_lo;
	logic [AW-1:0] waddr;
	logic [7:0]    wdata;
	logic [AW-1:0] raddr;
	logic [7:0]    rhi;
	logic [2:0]    rlo;

	modport ctrl (output we_hi, we_lo, waddr, wdata, raddr, input rhi, rlo);
	modport mem  (input we_hi, we_lo, waddr, wdata, raddr, output rhi, rlo);
endinterface

// >>> hw/csid_tag_mem.sv
/*
 * Per-object standard identifier tag storage, read data registered.
 * Assumes no reset: tag contents are undefined until software writes them.
 */
`timescale 1ns/10ps
`include "csid_defs.svh"

module csid_tag_mem #(
	parameter int DEPTH = 15,
	parameter int AW    = 4
) (
	input wire logic ref_clk,
	csid_tag_if.mem  port
);
	logic [7:0] hi_mem [DEPTH];
	logic [2:0] lo_mem [DEPTH];

	if (DEPTH > (1 << AW)) begin : g_chk
		$error("csid_tag_mem: DEPTH exceeds address range");
	end

	// byte writes and registered read of the selected object
	always_ff @(posedge ref_clk) begin
		if (port.we_hi) begin
			hi_mem[port.waddr] <= port.wdata;
		end
		if (port.we_lo) begin
			lo_mem[port.waddr] <= port.wdata[7:`CSID_TAG_LO_LSB];
		end
		port.rhi <= hi_mem[port.raddr];
		port.rlo <= lo_mem[port.raddr];
	end
endmodule

// >>> hw/csid_obj_status.sv
/*
 * Message object status flags, frame error checks and standard id tags.
 * Assumes a protocol sequencer that gives one bit_tick per bit time with
 * the current field, levels driven and monitored, and completion pulses;
 * the page pointer object number and object configuration come as inputs.
 */
`timescale 1ns/10ps
`include "csid_defs.svh"

// Functional notes
// - received length code unlike configured one sets length mismatch warning.
// - status and tag registers follow the object picked by the page number.
// - format bit clear means 11-bit tags, set means tag writes are dropped and tags read zero.
// - status at B2, bits: length, tx done, rx done, bit, stuff, crc, form, ack.
// - transmit done, bit 6, set when the object's transmission finishes.
// - lowest enabled index among 0..13 is transmitted first.
// - receive done, bit 5, set when the object's reception finishes.
// - a frame hitting several receivers updates only the lowest index.
// - bit error, bit 4, when monitored level differs from driven level while transmitting.
// - no bit error for lost arbitration, ack slot or error frame dominant.
// - crc computed over destuffed bits from start of frame through data.
// - when not transmitting, crc mismatch with received crc field sets crc error, bit 2.
// - wrong level in crc delimiter, ack delimiter or end sets form error.
// - each done and error flag gives an interrupt event when set.
// - tag high at BC holds identifier bits 10..3.
// - tag low at BD holds identifier bits 2..0 in 7..5, rest reserved.
// - tags have no reset value; software writes them before enabling.
module csid_obj_status #(
	parameter int NUM_OBJ  = 15,
	parameter int NUM_PRIO = 14
) (
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	input  wire logic [7:0]           sfr_addr,
	input  wire logic                 sfr_wr,
	input  wire logic                 sfr_rd,
	input  wire logic [7:0]           sfr_wdata,
	output logic [7:0]                sfr_rdata,
	input  wire logic [3:0]           object_number_field,
	input  wire logic [NUM_OBJ-1:0]   identifier_format_bit,
	input  wire logic [4*NUM_OBJ-1:0] data_length_code,
	input  wire logic [NUM_PRIO-1:0]  tx_enable,
	input  wire logic                 tx_done,
	input  wire logic                 rx_done,
	input  wire logic [NUM_PRIO-1:0]  rx_hit,
	input  wire logic [3:0]           rx_dlc,
	input  wire logic                 bit_tick,
	input  csid_pkg::csid_fld_t       fld,
	input  wire logic                 tx_bit,
	input  wire logic                 rx_bit,
	input  wire logic                 transmitting,
	output logic [3:0]                tx_obj,
	output logic                      tx_obj_valid,
	output logic [6:0]                status_set_evt
);
	if (NUM_OBJ > 16 || NUM_PRIO > NUM_OBJ || NUM_PRIO < 1) begin : g_chk
		$error("csid_obj_status: object counts out of range");
	end

	csid_tag_if #(.AW(4)) tag_bus ();

	csid_tag_mem #(.DEPTH(NUM_OBJ), .AW(4)) u_tag_mem (
		.ref_clk (ref_clk),
		.port    (tag_bus.mem)
	);

	// lowest set index of a request vector
	function automatic logic [3:0] lowest(input logic [NUM_PRIO-1:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = NUM_PRIO - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	logic [7:0]           status_reg [NUM_OBJ];
	logic [7:0]           status_next [NUM_OBJ];
	logic [7:0]           sfr_rdata_reg;
	logic [7:0]           sfr_rdata_next;
	logic [6:0]           evt_reg;
	logic [6:0]           evt_next;
	logic [3:0]           tx_obj_reg;
	logic [3:0]           tx_obj_next;
	logic                 tx_act_reg;
	logic                 tx_act_next;
	csid_pkg::csid_state_t state_reg;
	csid_pkg::csid_state_t state_next;
	logic [2:0]           run_reg;
	logic [2:0]           run_next;
	logic                 last_reg;
	logic                 last_next;
	logic [14:0]          crc_reg;
	logic [14:0]          crc_next;
	logic [14:0]          crc_rx_reg;
	logic [14:0]          crc_rx_next;
	logic                 sel_ok;
	logic                 sel_std;
	logic [3:0]           rx_obj;
	logic                 dlc_diff;
	logic [3:0]           err_obj;
	logic [4:0]           err_vec;
	logic                 stuff_bit;
	logic                 in_stuffed;
	logic [7:0]           sel_status;

	assign sel_ok  = int'(object_number_field) < NUM_OBJ;
	assign sel_std = sel_ok && !identifier_format_bit[object_number_field];
	assign rx_obj  = lowest(rx_hit);
	assign dlc_diff = rx_dlc != data_length_code[4*rx_obj +: 4];
	assign err_obj = tx_act_reg ? tx_obj_reg : object_number_field;
	assign sel_status = sel_ok ? status_reg[object_number_field] : `CSID_STATUS_RST;

	// transmit arbitration among enabled objects
	assign tx_obj       = lowest(tx_enable);
	assign tx_obj_valid = |tx_enable;
	assign sfr_rdata      = sfr_rdata_reg;
	assign status_set_evt = evt_reg;

	// tag memory port: writes only in standard format, reserved bits dropped
	assign tag_bus.waddr = object_number_field;
	assign tag_bus.wdata = sfr_wdata;
	assign tag_bus.raddr = object_number_field;
	assign tag_bus.we_hi = sfr_wr && sel_std && sfr_addr == `CSID_ADDR_TAG_HI;
	assign tag_bus.we_lo = sfr_wr && sel_std && sfr_addr == `CSID_ADDR_TAG_LO;

	// frame checker: destuffing, crc, bit, form and ack checks
	localparam logic [14:0] crc_init = `CSID_CRC_INIT;
	assign in_stuffed = state_reg == csid_pkg::ST_BODY || state_reg == csid_pkg::ST_CRC;
	assign stuff_bit  = in_stuffed && run_reg == `CSID_STUFF_RUN;

	always_comb begin
		logic fb;
		fb          = 1'b0;
		state_next  = state_reg;
		run_next    = run_reg;
		last_next   = last_reg;
		crc_next    = crc_reg;
		crc_rx_next = crc_rx_reg;
		tx_obj_next = tx_obj_reg;
		tx_act_next = tx_act_reg;
		err_vec     = 5'h00;
		if (bit_tick) begin
			if (transmitting && tx_bit != rx_bit && fld != csid_pkg::FLD_ACK_SLOT
				&& !(fld == csid_pkg::FLD_ARB && tx_bit && !rx_bit)
				&& !(fld == csid_pkg::FLD_ERROR && !rx_bit)) begin
				err_vec[`CSID_BIT_BIT_ERROR_FLAG] = 1'b1;
			end
			if (!rx_bit && (fld == csid_pkg::FLD_CRC_DELIM || fld == csid_pkg::FLD_ACK_DELIM
				|| fld == csid_pkg::FLD_EOF)) begin
				err_vec[`CSID_BIT_FORM_ERROR_FLAG] = 1'b1;
			end
			if (transmitting && fld == csid_pkg::FLD_ACK_SLOT && rx_bit) begin
				err_vec[`CSID_BIT_ACK_ERROR_FLAG] = 1'b1;
			end
			if (stuff_bit) begin
				if (rx_bit == last_reg) begin
					err_vec[`CSID_BIT_STUFF_ERROR_FLAG] = 1'b1;
				end
				run_next  = 3'h1;
				last_next = rx_bit;
			end else if (in_stuffed) begin
				run_next  = rx_bit == last_reg ? run_reg + 3'h1 : 3'h1;
				last_next = rx_bit;
			end
			unique case (state_reg)
				csid_pkg::ST_IDLE: begin
					if (fld == csid_pkg::FLD_SOF) begin
						state_next = csid_pkg::ST_BODY;
						run_next   = 3'h1;
						last_next  = rx_bit;
						fb         = rx_bit ^ crc_init[14];
						crc_next   = {crc_init[13:0], 1'b0} ^ (fb ? `CSID_CRC_POLY : 15'h0000);
						tx_act_next = transmitting && tx_obj_valid;
						tx_obj_next = tx_obj;
					end
				end
				csid_pkg::ST_BODY: begin
					if (fld == csid_pkg::FLD_CRC) begin
						state_next = csid_pkg::ST_CRC;
					end
					if (!stuff_bit && fld == csid_pkg::FLD_CRC) begin
						crc_rx_next = {crc_rx_reg[13:0], rx_bit};
					end else if (!stuff_bit) begin
						fb       = rx_bit ^ crc_reg[14];
						crc_next = {crc_reg[13:0], 1'b0} ^ (fb ? `CSID_CRC_POLY : 15'h0000);
					end
				end
				csid_pkg::ST_CRC: begin
					if (fld == csid_pkg::FLD_CRC_DELIM) begin
						state_next = csid_pkg::ST_TAIL;
						run_next   = 3'h0;
						if (!transmitting && crc_rx_reg != crc_reg) begin
							err_vec[`CSID_BIT_CRC_ERROR_FLAG] = 1'b1;
						end
					end else if (!stuff_bit) begin
						crc_rx_next = {crc_rx_reg[13:0], rx_bit};
					end
				end
				csid_pkg::ST_TAIL: begin
					run_next = 3'h0;
				end
			endcase
			if (fld == csid_pkg::FLD_IDLE || fld == csid_pkg::FLD_ERROR) begin
				state_next = csid_pkg::ST_IDLE;
				run_next   = 3'h0;
			end
			if (err_vec[`CSID_BIT_STUFF_ERROR_FLAG]) begin
				state_next = csid_pkg::ST_IDLE;
			end
		end
		if (tx_done) begin
			tx_act_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg  <= csid_pkg::ST_IDLE;
			run_reg    <= 3'h0;
			last_reg   <= 1'b1;
			crc_reg    <= `CSID_CRC_INIT;
			crc_rx_reg <= `CSID_CRC_INIT;
			tx_obj_reg <= 4'h0;
			tx_act_reg <= 1'b0;
		end else begin
			state_reg  <= state_next;
			run_reg    <= run_next;
			last_reg   <= last_next;
			crc_reg    <= crc_next;
			crc_rx_reg <= crc_rx_next;
			tx_obj_reg <= tx_obj_next;
			tx_act_reg <= tx_act_next;
		end
	end

	// status flags: software write stores, hardware set wins the same cycle
	always_comb begin
		logic [7:0] set_v;
		set_v    = 8'h00;
		evt_next = 7'h00;
		for (int o = 0; o < NUM_OBJ; o++) begin
			set_v = 8'h00;
			if (tx_done && tx_act_reg && int'(tx_obj_reg) == o) begin
				set_v[`CSID_BIT_TRANSMIT_DONE_FLAG] = 1'b1;
			end
			if (rx_done && |rx_hit && int'(rx_obj) == o) begin
				set_v[`CSID_BIT_RECEIVE_DONE_FLAG] = 1'b1;
				set_v[`CSID_BIT_LENGTH_MISMATCH_WARNING] = dlc_diff;
			end
			if (int'(err_obj) == o) begin
				set_v[4:0] = set_v[4:0] | err_vec;
			end
			status_next[o] = status_reg[o];
			if (sfr_wr && sfr_addr == `CSID_ADDR_STATUS && int'(object_number_field) == o) begin
				status_next[o] = sfr_wdata;
			end
			status_next[o] = status_next[o] | set_v;
			evt_next = evt_next | set_v[6:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		for (int o = 0; o < NUM_OBJ; o++) begin
			status_reg[o] <= rst ? `CSID_STATUS_RST : status_next[o];
		end
		evt_reg <= rst ? 7'h00 : evt_next;
	end

	// register read mux; reserved and unused bits read zero
	always_comb begin
		sfr_rdata_next = sfr_rdata_reg;
		if (sfr_rd) begin
			unique case (sfr_addr)
				`CSID_ADDR_STATUS: sfr_rdata_next = sel_status;
				`CSID_ADDR_TAG_HI: sfr_rdata_next = sel_std ? tag_bus.rhi : 8'h00;
				`CSID_ADDR_TAG_LO: sfr_rdata_next = sel_std ? {tag_bus.rlo, 5'h00} : 8'h00;
				`CSID_ADDR_TAG_UN: sfr_rdata_next = 8'h00;
				default:           sfr_rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		sfr_rdata_reg <= rst ? `CSID_RDATA_RST : sfr_rdata_next;
	end

	// checks
	AST_TX_PRIO: assert property (@(posedge ref_clk) disable iff (rst)
		tx_obj_valid |-> tx_enable[tx_obj] && (tx_enable & ((NUM_PRIO'(1) << tx_obj) - NUM_PRIO'(1))) == '0)
		else $error("transmit object is not the lowest enabled");
	AST_TRANSMIT_DONE_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
		tx_done && tx_act_reg |=> status_reg[$past(tx_obj_reg)][`CSID_BIT_TRANSMIT_DONE_FLAG] && evt_reg[`CSID_BIT_TRANSMIT_DONE_FLAG])
		else $error("transmit done flag not set");
	AST_RECEIVE_DONE_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
		rx_done && |rx_hit |=> status_reg[$past(rx_obj)][`CSID_BIT_RECEIVE_DONE_FLAG])
		else $error("receive done not set on lowest hit");
	AST_LENGTH_MISMATCH_WARNING: assert property (@(posedge ref_clk) disable iff (rst)
		rx_done && |rx_hit && dlc_diff |=> status_reg[$past(rx_obj)][`CSID_BIT_LENGTH_MISMATCH_WARNING])
		else $error("length warning not set");
	AST_BIT_ERROR_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
		bit_tick && transmitting && fld == csid_pkg::FLD_DATA && tx_bit != rx_bit |=> evt_reg[`CSID_BIT_BIT_ERROR_FLAG])
		else $error("bit error missed");
	AST_NO_BIT_ERROR_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
		bit_tick && (fld == csid_pkg::FLD_ACK_SLOT || (fld == csid_pkg::FLD_ARB && !rx_bit))
		|=> !evt_reg[`CSID_BIT_BIT_ERROR_FLAG])
		else $error("bit error flagged in exempt case");
	AST_STUFF_ERROR_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
		bit_tick && stuff_bit && rx_bit == last_reg |=> evt_reg[`CSID_BIT_STUFF_ERROR_FLAG] && state_reg == csid_pkg::ST_IDLE)
		else $error("stuff error missed");
	AST_FORM_ERROR_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
		bit_tick && !rx_bit && fld == csid_pkg::FLD_EOF |=> evt_reg[`CSID_BIT_FORM_ERROR_FLAG])
		else $error("form error missed");
	AST_ACK_ERROR_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
		bit_tick && transmitting && fld == csid_pkg::FLD_ACK_SLOT |=> evt_reg[`CSID_BIT_ACK_ERROR_FLAG] == $past(rx_bit))
		else $error("ack error wrong");
	AST_STATUS_RD: assert property (@(posedge ref_clk) disable iff (rst)
		sfr_rd && sfr_addr == `CSID_ADDR_STATUS |=> sfr_rdata == $past(sel_status))
		else $error("status read mismatch");
endmodule

// >>> sim/csid_bus_node.sv
/*
 * far-side bus node: wired-and of our driven level with its own level.
 * assumes dominant is 0 and the bench sets the node level once per bit time.
 */
`timescale 1ns/10ps

module csid_bus_node (
	input  wire logic tx_bit,
	output logic      rx_bit
);
	logic node_bit = 1'b1; // released node reads recessive

	// any dominant driver pulls the bus low
	assign rx_bit = tx_bit & node_bit;

	// node level for the coming bit
	task automatic drive(input logic b);
		node_bit = b;
	endtask
endmodule

// >>> sim/csid_obj_status_tb.sv
/*
 * bench of the object status block: reference model compared at every read.
 * assumes design, package, interface, defines header and bus node compiled first.
 */
`timescale 1ns/10ps
`include "csid_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module csid_obj_status_tb;
	logic                ref_clk, rst, sfr_wr, sfr_rd, bit_tick, tx_bit, rx_bit, last, evt_clr;
	logic                transmitting, tx_done, rx_done, tx_obj_valid;
	logic [7:0]          sfr_addr, sfr_wdata, sfr_rdata;
	logic [3:0]          object_number_field, rx_dlc, tx_obj;
	logic [14:0]         identifier_format_bit, crc;
	logic [59:0]         data_length_code;
	logic [13:0]         tx_enable, rx_hit;
	logic [6:0]          status_set_evt, evt_seen, evt_exp;
	csid_pkg::csid_fld_t fld;
	logic [7:0]          exp_st [15];
	logic [10:0]         ids [15];
	int                  failures, samples_checked, run, t;
	int                  bads [4] = '{0, 6, 8, 9};

	// 20 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	csid_obj_status uut (
		.ref_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .object_number_field,
		.identifier_format_bit, .data_length_code, .tx_enable, .tx_done, .rx_done, .rx_hit, .rx_dlc,
		.bit_tick, .fld, .tx_bit, .rx_bit, .transmitting, .tx_obj, .tx_obj_valid, .status_set_evt
	);

	csid_bus_node node (
		.tx_bit,
		.rx_bit
	);

	// gather interrupt events between checks
	always @(posedge ref_clk)
		if (rst || evt_clr)
			evt_seen <= 7'h00;
		else
			evt_seen <= evt_seen | status_set_evt;

	// bench helpers: edge step, register access, bit times
	task automatic step;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [3:0] o, input logic [7:0] d);
		object_number_field = o;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		step();
		sfr_wr = 1'b0;
		step();
	endtask

	task automatic rd(input logic [7:0] a, input logic [3:0] o, input logic [7:0] e);
		object_number_field = o;
		sfr_addr = a;
		step();
		sfr_rd = 1'b1;
		step();
		sfr_rd = 1'b0;
		step();
		`CHK(sfr_rdata, e)
	endtask

	task automatic tick(input csid_pkg::csid_fld_t f, input logic b, input logic nb);
		fld = f;
		tx_bit = b;
		node.drive(nb);
		bit_tick = 1'b1;
		step();
		bit_tick = 1'b0;
		step();
	endtask

	// one level by whichever side sends the frame
	task automatic put(input csid_pkg::csid_fld_t f, input logic b);
		if (transmitting)
			tick(f, b, 1'b1);
		else
			tick(f, 1'b1, b);
	endtask

	// stuffed bit: crc over the body, stuff bit after five equal levels
	task automatic sb(input csid_pkg::csid_fld_t f, input logic b);
		put(f, b);
		if (f != csid_pkg::FLD_CRC)
			crc = {crc[13:0], 1'b0} ^ ((b ^ crc[14]) ? `CSID_CRC_POLY : 15'h0000);
		run = (b == last) ? run + 1 : 1;
		last = b;
		if (run == 5) begin
			put(f, ~b);
			last = ~b;
			run = 1;
		end
	endtask

	// whole frame; bad picks a fixed-form bit to spoil, flip spoils the crc
	task automatic frame(input logic ack, input logic flip, input int bad);
		logic [25:0] body;
		logic [14:0] c;
		body = 26'($urandom);
		crc = 15'h0000;
		run = 0;
		last = 1'b1;
		sb(csid_pkg::FLD_SOF, 1'b0);
		for (int i = 0; i < 26; i++)
			sb(i < 12 ? csid_pkg::FLD_ARB : i < 18 ? csid_pkg::FLD_CTRL : csid_pkg::FLD_DATA, body[i]);
		c = crc ^ {14'h0, flip};
		for (int i = 14; i >= 0; i--)
			sb(csid_pkg::FLD_CRC, c[i]);
		tick(csid_pkg::FLD_CRC_DELIM, 1'b1, bad != 6);
		if (transmitting)
			tick(csid_pkg::FLD_ACK_SLOT, 1'b1, !ack);
		else
			tick(csid_pkg::FLD_ACK_SLOT, 1'b0, 1'b1);
		tick(csid_pkg::FLD_ACK_DELIM, 1'b1, bad != 8);
		for (int i = 0; i < 7; i++)
			tick(csid_pkg::FLD_EOF, 1'b1, !(bad == 9 && i == 3));
		tx_done = transmitting & ack;
		step();
		tx_done = 1'b0;
		tick(csid_pkg::FLD_IDLE, 1'b1, 1'b1);
	endtask

	// model: lowest set index, expected flag sets
	function automatic int low(input logic [13:0] v);
		low = 14;
		for (int i = 13; i >= 0; i--)
			if (v[i])
				low = i;
	endfunction

	task automatic mark(input int o, input logic [7:0] m);
		exp_st[o] |= m;
		evt_exp |= m[6:0];
	endtask

	// compare the event record, then compare and clear every object's status, then clear the record
	task automatic chk_all;
		`CHK(evt_seen, evt_exp)
		for (int o = 0; o < 15; o++) begin
			rd(`CSID_ADDR_STATUS, 4'(o), exp_st[o]);
			wr(`CSID_ADDR_STATUS, 4'(o), 8'h00);
			exp_st[o] = 8'h00;
		end
		evt_clr = 1'b1;
		step();
		evt_clr = 1'b0;
		evt_exp = 7'h00;
	endtask

	task automatic stop_test;
		if (failures == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// watchdog well beyond the expected run
	initial begin
		#1000000;
		failures++;
		stop_test();
	end

	// main sequence
	initial begin
		void'($urandom(84));
		failures = 0;
		samples_checked = 0;
		rst = 1'b1;
		tx_bit = 1'b1;
		fld = csid_pkg::FLD_IDLE;
		{sfr_wr, sfr_rd, bit_tick, tx_done, rx_done, transmitting, evt_clr} = '0;
		{sfr_addr, sfr_wdata, object_number_field, rx_dlc, tx_enable, rx_hit, evt_exp} = '0;
		identifier_format_bit = (15'($urandom) & ~15'h0001) | 15'h0002;
		for (int o = 0; o < 15; o++) begin
			data_length_code[4*o +: 4] = 4'($urandom % 9);
			exp_st[o] = 8'h00;
		end
		repeat (5) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		chk_all();
		rd(`CSID_ADDR_STATUS, 4'hF, 8'h00);
		rd(`CSID_ADDR_TAG_UN, 4'h0, 8'h00);
		rd(8'hB5, 4'h0, 8'h00);
		// tags: standard objects keep id bits, extended ones read zero
		for (int o = 0; o < 15; o++) begin
			ids[o] = 11'($urandom);
			wr(`CSID_ADDR_TAG_HI, 4'(o), ids[o][10:3]);
			wr(`CSID_ADDR_TAG_LO, 4'(o), {ids[o][2:0], 5'h00});
		end
		for (int o = 0; o < 15; o++) begin
			rd(`CSID_ADDR_TAG_HI, 4'(o), identifier_format_bit[o] ? 8'h00 : ids[o][10:3]);
			rd(`CSID_ADDR_TAG_LO, 4'(o), identifier_format_bit[o] ? 8'h00 : {ids[o][2:0], 5'h00});
		end
		// lowest enabled index wins, from each starting index
		for (int k = 0; k < 14; k++) begin
			tx_enable = (14'($urandom) | 14'h2000) & (14'h3FFF << k);
			step();
			`CHK(tx_obj, 4'(low(tx_enable)))
			`CHK(tx_obj_valid, 1'b1)
		end
		tx_enable = 14'h0000;
		step();
		`CHK(tx_obj_valid, 1'b0)
		object_number_field = 4'hE;
		// transmit with and without an acknowledge
		for (int a = 1; a >= 0; a--) begin
			tx_enable = 14'($urandom) | 14'h2000;
			t = low(tx_enable);
			transmitting = 1'b1;
			frame(a[0], 1'b0, 0);
			transmitting = 1'b0;
			mark(t, a ? 8'h40 : 8'h01);
			chk_all();
		end
		// bit error in data, none for lost arbitration or an error frame
		transmitting = 1'b1;
		t = low(tx_enable);
		tick(csid_pkg::FLD_SOF, 1'b0, 1'b1);
		tick(csid_pkg::FLD_ARB, 1'b1, 1'b0);
		tick(csid_pkg::FLD_DATA, 1'b1, 1'b0);
		tick(csid_pkg::FLD_ERROR, 1'b1, 1'b0);
		tick(csid_pkg::FLD_IDLE, 1'b1, 1'b1);
		transmitting = 1'b0;
		mark(t, 8'h10);
		chk_all();
		// good receptions, the second with a length unlike the configured one
		for (int a = 0; a < 2; a++) begin
			frame(1'b1, 1'b0, 0);
			rx_hit = 14'($urandom) | 14'h2000;
			t = low(rx_hit);
			rx_dlc = data_length_code[4*t +: 4] ^ 4'(a);
			rx_done = 1'b1;
			step();
			rx_done = 1'b0;
			mark(t, a ? 8'hA0 : 8'h20);
			step();
			chk_all();
		end
		// spoiled crc, then one bit of each fixed-form field in turn
		foreach (bads[k]) begin
			frame(1'b1, k == 0, bads[k]);
			mark(14, k ? 8'h02 : 8'h04);
			chk_all();
		end
		// six equal levels with no stuff bit
		tick(csid_pkg::FLD_SOF, 1'b1, 1'b0);
		repeat (5) tick(csid_pkg::FLD_ARB, 1'b1, 1'b0);
		tick(csid_pkg::FLD_IDLE, 1'b1, 1'b1);
		mark(14, 8'h08);
		chk_all();
		stop_test();
	end
endmodule
